//--- mfsf_alu.sv
// Purpose: 16/32-bit add/subtract unit with carry, overflow and sign flags
// Assumes: Subtract is a + ~b + 1, so carry means no borrow
// Notes:   Divide step primitive is not handled here
module mfsf_alu (
  mfsf_alu_if.unit u
);
  import mfsf_pkg::*;

  logic [31:0] bb;
  logic [32:0] sum;
  logic msb_a;
  logic msb_b;
  logic msb_r;

  always_comb begin
    bb = u.sub ? ~u.b : u.b;
    if (u.wide) begin // RL1
      sum = {1'b0, u.a} + {1'b0, bb} + {32'h0000_0000, u.sub};
      u.res = sum[31:0];
      u.carry = sum[32]; // RL7
      msb_a = u.a[31];
      msb_b = bb[31];
      msb_r = sum[31];
    end else begin
      sum = {16'h0000, {1'b0, u.a[15:0]} + {1'b0, bb[15:0]} + {16'h0000, u.sub}};
      u.res = {16'h0000, sum[15:0]};
      u.carry = sum[16]; // RL7
      msb_a = u.a[15];
      msb_b = bb[15];
      msb_r = sum[15];
    end
    // Mixed-sign addends cannot overflow: msb_a differs from msb_b
    u.ovf = (msb_a == msb_b) && (msb_r != msb_a); // RL2 RL5 RL6
    u.neg = msb_r; // RL18
  end

endmodule : mfsf_alu

//--- mfsf_core.sv
// Purpose: Status flags, accumulators, shifter and AXI4-Lite registers
// Assumes: Sequencer issues one single-cycle operation per accepted valid
// Notes:   Status bits reflect the latest operation; stickies clear by write
//
// Function
// RL1: ALU operands are 16 or 32-bit strings
// RL2: ALU flags read results as signed
// RL3: Per-unit sticky overflow until status write
// RL4: Transfer overflow flag and sticky copy
// RL5: Overflow uses two's-complement sign rules
// RL6: Mixed-sign addition never overflows
// RL7: Carry out of the top bit
// RL8: Multiplier operand signedness per instruction
// RL9: Product sign-extended to 40 bits
// RL10: Fractional product shifted left one bit
// RL11: Integer product passes unshifted
// RL12: Product bit 31 lands on bit 32
// RL13: Product feeds 40-bit adder/subtracter
// RL14: Multiplier status on accumulate and transfer
// RL15: Logical shifts unsigned, arithmetic shifts signed
// RL16: Exponent detect reads two's-complement input
// RL17: Status reflects the most recent operation
// RL18: Negative flag is result top bit
module mfsf_core (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_op_valid,
  input wire mfsf_pkg::mfsf_op_t i_op_code,
  input wire logic i_op_unit,
  input wire logic i_op_frac,
  input wire logic i_op_a_signed,
  input wire logic i_op_b_signed,
  input wire logic i_op_rnd,
  input wire logic [31:0] i_op_a,
  input wire logic [31:0] i_op_b,
  output logic o_res_valid,
  output logic [31:0] o_res_lo,
  output logic [31:0] o_res_hi,
  output logic [8:0] o_status
);
  import mfsf_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [8:0] arith_status_reg;
  logic [8:0] arith_status_next;
  logic [0:0] ctrl_reg;
  logic [39:0] accumulator_zero_reg;
  logic [39:0] accumulator_one_reg;
  logic [39:0] acc_sel;
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [31:0] wmask;
  logic wr_go;
  logic wr_status;
  logic rd_go;
  logic op_go;
  logic is_alu;
  logic is_mac;
  logic xovf0;
  logic xovf1;
  logic [31:0] shift_res;
  logic [31:0] res_lo_next;
  logic [31:0] res_hi_next;

  mfsf_alu_if alu_if ();
  mfsf_mac_if mac_if ();

  mfsf_alu u_alu (.u(alu_if.unit));
  mfsf_mac u_mac (.u(mac_if.unit));

  // ----------------------------------------------------------------
  // Operation decode and unit operands
  // ----------------------------------------------------------------
  // Operations are dropped while software has the datapath disabled
  assign op_go = i_ce && i_op_valid && ctrl_reg[CTRL_EN_BIT];
  assign is_alu = (i_op_code == OP_ADD16) || (i_op_code == OP_SUB16) ||
                  (i_op_code == OP_ADD32) || (i_op_code == OP_SUB32);
  assign is_mac = (i_op_code == OP_MUL) || (i_op_code == OP_MAC) || (i_op_code == OP_MSC);
  assign acc_sel = i_op_unit ? accumulator_one_reg : accumulator_zero_reg;

  assign alu_if.a = i_op_a;
  assign alu_if.b = i_op_b;
  assign alu_if.wide = (i_op_code == OP_ADD32) || (i_op_code == OP_SUB32); // RL1
  assign alu_if.sub = (i_op_code == OP_SUB16) || (i_op_code == OP_SUB32);

  assign mac_if.a16 = i_op_a[15:0];
  assign mac_if.b16 = i_op_b[15:0];
  assign mac_if.a_signed = i_op_a_signed; // RL8
  assign mac_if.b_signed = i_op_b_signed; // RL8
  assign mac_if.frac = i_op_frac;
  assign mac_if.sub = (i_op_code == OP_MSC);
  assign mac_if.rnd = i_op_rnd;
  assign mac_if.acc_in = (i_op_code == OP_MUL) ? 40'h00_0000_0000 : acc_sel; // RL13

  // Transfer overflows when the top nine bits are not a pure sign run
  assign xovf0 = !((&accumulator_zero_reg[39:31]) || !(|accumulator_zero_reg[39:31]));
  assign xovf1 = !((&accumulator_one_reg[39:31]) || !(|accumulator_one_reg[39:31]));

  // ----------------------------------------------------------------
  // Shifter and exponent detection
  // ----------------------------------------------------------------
  function automatic logic [31:0] sign_run(input logic [31:0] v);
    logic [31:0] n;
    logic stop;
    n = 32'h0000_0000;
    stop = 1'b0;
    for (int i = 30; i >= 0; i--) begin
      if (!stop && (v[i] == v[31])) begin
        n = n + 32'h0000_0001;
      end else begin
        stop = 1'b1;
      end
    end
    return n;
  endfunction : sign_run

  always_comb begin
    case (i_op_code)
      OP_LSL: shift_res = i_op_a << i_op_b[4:0]; // RL15
      OP_LSR: shift_res = i_op_a >> i_op_b[4:0]; // RL15
      OP_ASR: shift_res = $unsigned($signed(i_op_a) >>> i_op_b[4:0]); // RL15
      default: shift_res = sign_run(i_op_a); // RL16
    endcase
  end

  always_comb begin
    res_hi_next = 32'h0000_0000;
    if (is_alu) begin
      res_lo_next = alu_if.res;
    end else if (is_mac) begin
      res_lo_next = mac_if.acc_out[31:0];
      res_hi_next = {24'h00_0000, mac_if.acc_out[39:32]};
    end else if (i_op_code == OP_XFER) begin
      res_lo_next = accumulator_zero_reg[31:0];
      res_hi_next = accumulator_one_reg[31:0];
    end else begin
      res_lo_next = shift_res;
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic status
  // ----------------------------------------------------------------
  // A status write lands first, so a same-cycle hardware set wins
  always_comb begin
    arith_status_next = arith_status_reg;
    if (wr_status) begin
      arith_status_next = (arith_status_reg & ~wmask[8:0]) | (wdata_reg[8:0] & wmask[8:0]); // RL3
    end
    if (op_go) begin // RL17
      if (is_alu) begin
        arith_status_next[ST_SIGN] = alu_if.neg; // RL2 RL18
        arith_status_next[i_op_unit ? ST_C1 : ST_C0] = alu_if.carry; // RL7
        arith_status_next[i_op_unit ? ST_V1 : ST_V0] = alu_if.ovf; // RL2
        if (alu_if.ovf) begin
          arith_status_next[i_op_unit ? ST_V1S : ST_V0S] = 1'b1; // RL3
        end
      end else if (is_mac) begin
        arith_status_next[ST_SIGN] = mac_if.acc_out[39]; // RL14 RL18
        arith_status_next[i_op_unit ? ST_V1 : ST_V0] = mac_if.ovf; // RL14
        if (mac_if.ovf) begin
          arith_status_next[i_op_unit ? ST_V1S : ST_V0S] = 1'b1; // RL3
        end
      end else if (i_op_code == OP_XFER) begin
        arith_status_next[ST_SIGN] = accumulator_zero_reg[31]; // RL14
        arith_status_next[ST_XV] = xovf0 || xovf1; // RL4
        if (xovf0 || xovf1) begin
          arith_status_next[ST_XVS] = 1'b1; // RL4
        end
      end else begin
        arith_status_next[ST_SIGN] = shift_res[31]; // RL18
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      arith_status_reg <= ST_RST;
    end else if (i_ce) begin
      arith_status_reg <= arith_status_next;
    end
  end

  // ----------------------------------------------------------------
  // Accumulators and result port
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      accumulator_zero_reg <= 40'h00_0000_0000;
      accumulator_one_reg <= 40'h00_0000_0000;
    end else if (op_go && is_mac) begin
      if (i_op_unit) begin
        accumulator_one_reg <= mac_if.acc_out; // RL13
      end else begin
        accumulator_zero_reg <= mac_if.acc_out; // RL13
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_res_valid <= 1'b0;
      o_res_lo <= 32'h0000_0000;
      o_res_hi <= 32'h0000_0000;
    end else if (i_ce) begin
      o_res_valid <= op_go;
      if (op_go) begin
        o_res_lo <= res_lo_next;
        o_res_hi <= res_hi_next;
      end
    end
  end

  assign o_status = arith_status_reg;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[8*gi +: 8] = {8{wstrb_reg[gi]}};
    end
  endgenerate

  assign wr_go = i_ce && aw_full_reg && w_full_reg && !o_s_axi_bvalid;
  assign wr_status = wr_go && (awaddr_reg == ARITH_STATUS_OFFS);

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready <= 1'b1;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= RESP_OKAY;
    end else if (i_ce) begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= i_s_axi_awaddr;
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_full_reg <= 1'b1;
        wdata_reg <= i_s_axi_wdata;
        wstrb_reg <= i_s_axi_wstrb;
        o_s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        if ((awaddr_reg == ARITH_STATUS_OFFS) || (awaddr_reg == CTRL_OFFS)) begin
          o_s_axi_bresp <= RESP_OKAY;
        end else begin
          o_s_axi_bresp <= RESP_SLVERR;
        end
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_go && (awaddr_reg == CTRL_OFFS) && wstrb_reg[0]) begin
      ctrl_reg <= wdata_reg[CTRL_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign rd_go = i_ce && i_s_axi_arvalid && o_s_axi_arready;

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= RESP_OKAY;
    end else if (i_ce) begin
      if (rd_go) begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rresp <= RESP_OKAY;
        if (i_s_axi_araddr == ARITH_STATUS_OFFS) begin
          o_s_axi_rdata <= {23'h00_0000, arith_status_reg};
        end else if (i_s_axi_araddr == CTRL_OFFS) begin
          o_s_axi_rdata <= {31'h0000_0000, ctrl_reg};
        end else if (i_s_axi_araddr == ACC0_LO_OFFS) begin
          o_s_axi_rdata <= accumulator_zero_reg[31:0];
        end else if (i_s_axi_araddr == ACC0_EXT_OFFS) begin
          o_s_axi_rdata <= {24'h00_0000, accumulator_zero_reg[39:32]};
        end else if (i_s_axi_araddr == ACC1_LO_OFFS) begin
          o_s_axi_rdata <= accumulator_one_reg[31:0];
        end else if (i_s_axi_araddr == ACC1_EXT_OFFS) begin
          o_s_axi_rdata <= {24'h00_0000, accumulator_one_reg[39:32]};
        end else begin
          o_s_axi_rdata <= 32'h0000_0000;
          o_s_axi_rresp <= RESP_SLVERR;
        end
      end
      if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
        o_s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_add_w0;
    op_go && (i_op_code == OP_ADD32) && !i_op_unit;
  endsequence

  sequence s_ar_take;
    rd_go;
  endsequence

  property p_sticky_hold;
    arith_status_reg[ST_V0S] && !wr_status |=> arith_status_reg[ST_V0S];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky overflow dropped"); // RL3

  property p_sticky_set;
    op_go && is_alu && i_op_unit && alu_if.ovf |=> arith_status_reg[ST_V1S] && arith_status_reg[ST_V1];
  endproperty
  a_sticky_set: assert property (p_sticky_set) else $error("sticky overflow not set"); // RL3

  property p_xfer_ovf;
    op_go && (i_op_code == OP_XFER) && (xovf0 || xovf1) |=>
      arith_status_reg[ST_XV] && arith_status_reg[ST_XVS];
  endproperty
  a_xfer_ovf: assert property (p_xfer_ovf) else $error("transfer overflow missed"); // RL4

  property p_mixed_sign;
    s_add_w0 ##0 (i_op_a[31] != i_op_b[31]) |=> !arith_status_reg[ST_V0];
  endproperty
  a_mixed_sign: assert property (p_mixed_sign) else $error("mixed sign add overflowed"); // RL6

  property p_sign_flag;
    s_add_w0 |=> arith_status_reg[ST_SIGN] == o_res_lo[31] ##1 o_res_lo == $past(o_res_lo) || o_res_valid;
  endproperty
  a_sign_flag: assert property (p_sign_flag) else $error("sign flag mismatch"); // RL18

  property p_carry16;
    op_go && (i_op_code == OP_ADD16) && !i_op_unit && (i_op_a[15:0] == 16'hffff) &&
      (i_op_b[15:0] != 16'h0000) |=> arith_status_reg[ST_C0];
  endproperty
  a_carry16: assert property (p_carry16) else $error("carry from top bit missed"); // RL7

  property p_frac_align;
    i_op_frac |-> (mac_if.adj[0] == 1'b0) && (mac_if.adj[39:32] == {8{mac_if.adj[32]}});
  endproperty
  a_frac_align: assert property (p_frac_align) else $error("fractional alignment wrong"); // RL10 RL12

  property p_int_align;
    !i_op_frac |-> mac_if.adj[39:31] == {9{mac_if.adj[31]}};
  endproperty
  a_int_align: assert property (p_int_align) else $error("integer product shifted"); // RL11

  property p_bvalid_hold;
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

  property p_read_answer;
    s_ar_take |=> o_s_axi_rvalid && !o_s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");

  property p_res_valid;
    op_go |=> o_res_valid;
  endproperty
  a_res_valid: assert property (p_res_valid) else $error("result valid missing"); // RL17

endmodule : mfsf_core

//--- mfsf_core_tb.sv
// Purpose: Self-checking bench for the datapath core
// Assumes: Clock enable held high; status bits at the package positions
// Notes:   Bus waits are bounded; a hang ends the run as a failure
module mfsf_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import mfsf_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst, i_ce, i_op_rnd, i_op_valid, i_op_unit, i_op_frac;
  logic i_op_a_signed, i_op_b_signed, o_res_valid;
  mfsf_op_t i_op_code;
  logic [31:0] i_op_a, i_op_b, o_res_lo, o_res_hi, i_s_axi_wdata, o_s_axi_rdata;
  logic [8:0] o_status;
  logic [7:0] i_s_axi_awaddr, i_s_axi_araddr;
  logic [3:0] i_s_axi_wstrb;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  logic i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready;
  logic o_s_axi_bvalid, i_s_axi_bready, i_s_axi_arvalid, o_s_axi_arready;
  logic o_s_axi_rvalid, i_s_axi_rready;
  int mismatches = 0;
  int samples_checked = 0;
  logic v;
  logic [63:0] r64;
  logic [31:0] d;
  logic [1:0] rs;

  always #10 i_sys_clk = ~i_sys_clk;

  mfsf_core dut (.i_sys_clk, .i_sys_rst, .i_ce, .i_s_axi_awaddr, .i_s_axi_awvalid,
    .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
    .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid,
    .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
    .i_op_valid, .i_op_code, .i_op_unit, .i_op_frac, .i_op_a_signed, .i_op_b_signed,
    .i_op_rnd, .i_op_a, .i_op_b, .o_res_valid, .o_res_lo, .o_res_hi, .o_status);

  mfsf_seq_model mdl (.i_sys_clk, .i_res_valid(o_res_valid), .i_res_lo(o_res_lo),
    .i_res_hi(o_res_hi), .o_op_valid(i_op_valid), .o_op_code(i_op_code),
    .o_op_unit(i_op_unit), .o_op_frac(i_op_frac), .o_op_a_signed(i_op_a_signed),
    .o_op_b_signed(i_op_b_signed), .o_op_a(i_op_a), .o_op_b(i_op_b));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task test_done();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task chk(input string nm, input logic [64:0] e, g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task tick(inout int n);
    n++;
    if (n > 40) begin
      mismatches++;
      test_done();
    end
  endtask : tick

  task run(input string nm, input mfsf_op_t c, input logic [3:0] m,
           input logic [31:0] a, b, input logic [63:0] e);
    mdl.issue(c, m, a, b, v, r64);
    chk(nm, {1'b1, e}, {v, r64});
  endtask : run

  // Address and data are offered together and released one by one
  task axw(input logic [7:0] ad, input logic [31:0] wd, output logic [1:0] r);
    int n;
    logic aw, w, ao, wo;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    @(posedge i_sys_clk);
    i_s_axi_awaddr <= ad;
    i_s_axi_wdata <= wd;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(negedge i_sys_clk);
      ao = aw && o_s_axi_awready === 1'b1;
      wo = w && o_s_axi_wready === 1'b1;
      @(posedge i_sys_clk);
      if (ao) i_s_axi_awvalid <= 1'b0;
      if (wo) i_s_axi_wvalid <= 1'b0;
      aw = aw && !ao;
      w = w && !wo;
      tick(n);
    end
    do begin @(negedge i_sys_clk); tick(n); end while (o_s_axi_bvalid !== 1'b1);
    r = o_s_axi_bresp;
    @(posedge i_sys_clk);
    i_s_axi_bready <= 1'b0;
  endtask : axw

  task axr(input logic [7:0] ad, output logic [31:0] rd, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_s_axi_araddr <= ad;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do begin @(negedge i_sys_clk); tick(n); end while (o_s_axi_arready !== 1'b1);
    @(posedge i_sys_clk);
    i_s_axi_arvalid <= 1'b0;
    do begin @(negedge i_sys_clk); tick(n); end while (o_s_axi_rvalid !== 1'b1);
    rd = o_s_axi_rdata;
    r = o_s_axi_rresp;
    @(posedge i_sys_clk);
    i_s_axi_rready <= 1'b0;
  endtask : axr

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_alu();
    run("add16", OP_ADD16, 4'h0, 32'h7fff, 32'h1, 64'h8000);
    chk("st_pos_ovf", 9'h019, o_status);
    run("add16_mix", OP_ADD16, 4'h0, 32'hffff, 32'h1, 64'h0);
    chk("st_mix", 9'h012, o_status);
    run("sub32", OP_SUB32, 4'h8, 32'h8000_0000, 32'h1, 64'h7fff_ffff);
    chk("st_sub", 4'b1110, {o_status[6:5], o_status[2], o_status[0]});
  endtask : t_alu

  task t_regs();
    axw(ARITH_STATUS_OFFS, 32'h0, rs);
    chk("bresp_st", RESP_OKAY, rs);
    axr(ARITH_STATUS_OFFS, d, rs);
    chk("st_cleared", 32'h0, d);
    axw(ACC0_LO_OFFS, 32'h1, rs);
    chk("bresp_ro", RESP_SLVERR, rs);
    axr(8'h40, d, rs);
    chk("rd_unmapped", {RESP_SLVERR, 32'h0}, {rs, d});
    axw(CTRL_OFFS, 32'h0, rs);
    mdl.issue(OP_ADD16, 4'h0, 32'h1, 32'h1, v, r64);
    chk("op_refused", 1'b0, v);
    axw(CTRL_OFFS, 32'h1, rs);
  endtask : t_regs

  task t_mac();
    run("mul_int", OP_MUL, 4'h3, 32'hffff, 32'h2, 64'hff_ffff_fffe);
    run("mac_frac", OP_MAC, 4'h7, 32'h4000, 32'h4000, 64'h1fff_fffe);
    run("msc_mixed", OP_MSC, 4'h1, 32'hffff, 32'h2, 64'h1ffe_0000);
    run("mul_frac1", OP_MUL, 4'hf, 32'h8000, 32'h8000, 64'h8000_0000);
    chk("st_mac_sign", 1'b0, o_status[ST_SIGN]);
    run("xfer", OP_XFER, 4'h0, 32'h0, 32'h0, 64'h8000_0000_1ffe_0000);
    chk("st_xfer", 2'b11, o_status[8:7]);
    run("add32", OP_ADD32, 4'h0, 32'h7fff_ffff, 32'h8000_0001, 64'h0);
    chk("st_xsticky", 1'b1, o_status[ST_XVS]);
    axw(ARITH_STATUS_OFFS, 32'h0, rs);
    chk("st_xclr", 9'h0, o_status);
  endtask : t_mac

  task t_shift();
    run("lsr", OP_LSR, 4'h0, 32'h8000_0000, 32'h4, 64'h0800_0000);
    run("asr", OP_ASR, 4'h0, 32'h8000_0000, 32'h4, 64'hf800_0000);
    chk("st_asr_sign", 1'b1, o_status[ST_SIGN]);
    run("lsl", OP_LSL, 4'h0, 32'h1, 32'h1f, 64'h8000_0000);
    run("exp_pos", OP_EXP, 4'h0, 32'h0000_1000, 32'h0, 64'd18);
    run("exp_neg", OP_EXP, 4'h0, 32'hffff_0000, 32'h0, 64'd15);
  endtask : t_shift

  initial begin
    i_sys_rst = 1'b1;
    {i_ce, i_op_rnd} = 2'b10;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = '0;
    i_s_axi_wstrb = 4'hf;
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = '0;
    {i_s_axi_arvalid, i_s_axi_rready} = '0;
    repeat (12) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_alu();
    t_regs();
    t_mac();
    t_shift();
    test_done();
  end
endmodule : mfsf_core_tb

//--- mfsf_ifs.sv
// Purpose: Carriers between the core and its arithmetic units
// Assumes: Units are purely combinational
// Notes:   Core drives operands, units return result and flags
interface mfsf_alu_if;
  logic [31:0] a;
  logic [31:0] b;
  logic wide;
  logic sub;
  logic [31:0] res;
  logic carry;
  logic ovf;
  logic neg;
  modport core (output a, b, wide, sub, input res, carry, ovf, neg);
  modport unit (input a, b, wide, sub, output res, carry, ovf, neg);
endinterface : mfsf_alu_if

interface mfsf_mac_if;
  logic [15:0] a16;
  logic [15:0] b16;
  logic a_signed;
  logic b_signed;
  logic frac;
  logic sub;
  logic rnd;
  logic [39:0] acc_in;
  logic [39:0] adj;
  logic [39:0] acc_out;
  logic ovf;
  modport core (output a16, b16, a_signed, b_signed, frac, sub, rnd, acc_in,
                input adj, acc_out, ovf);
  modport unit (input a16, b16, a_signed, b_signed, frac, sub, rnd, acc_in,
                output adj, acc_out, ovf);
endinterface : mfsf_mac_if

//--- mfsf_mac.sv
// Purpose: 16x16 multiplier with format adjustment and 40-bit adder/subtracter
// Assumes: Operand signedness comes from the instruction
// Notes:   Rounding adds a bias at bit 15 before accumulation
module mfsf_mac (
  mfsf_mac_if.unit u
);
  import mfsf_pkg::*;

  logic signed [16:0] sa;
  logic signed [16:0] sb;
  logic signed [33:0] prod;
  logic [31:0] p;
  logic [39:0] addend;

  always_comb begin
    sa = {u.a_signed & u.a16[15], u.a16}; // RL8
    sb = {u.b_signed & u.b16[15], u.b16}; // RL8
    prod = sa * sb;
    p = prod[31:0];
    if (u.frac) begin
      u.adj = {{7{p[31]}}, p, 1'b0}; // RL9 RL10 RL12
    end else begin
      u.adj = {{8{p[31]}}, p}; // RL9 RL11
    end
    addend = u.rnd ? u.adj + RND_ADD : u.adj;
    if (u.sub) begin
      u.acc_out = u.acc_in - addend; // RL13
      u.ovf = (u.acc_in[39] != addend[39]) && (u.acc_out[39] != u.acc_in[39]); // RL5
    end else begin
      u.acc_out = u.acc_in + addend; // RL13
      u.ovf = (u.acc_in[39] == addend[39]) && (u.acc_out[39] != u.acc_in[39]); // RL5
    end
  end

endmodule : mfsf_mac

//--- mfsf_pkg.sv
// Purpose: Shared constants and types for the MAC format and status flag datapath
// Assumes: 50 MHz core clock, AXI4-Lite register access with 32-bit data
// Notes:   Status layout and register offsets are shared by core and bench
package mfsf_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ACC_W = 40;
  localparam int ST_W = 9;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ARITH_STATUS_OFFS = 8'h00;
  localparam logic [7:0] CTRL_OFFS = 8'h04;
  localparam logic [7:0] ACC0_LO_OFFS = 8'h08;
  localparam logic [7:0] ACC0_EXT_OFFS = 8'h0c;
  localparam logic [7:0] ACC1_LO_OFFS = 8'h10;
  localparam logic [7:0] ACC1_EXT_OFFS = 8'h14;

  // ----------------------------------------------------------------
  // Status field positions and reset values
  // ----------------------------------------------------------------
  localparam int ST_SIGN = 0;
  localparam int ST_C0 = 1;
  localparam int ST_C1 = 2;
  localparam int ST_V0 = 3;
  localparam int ST_V0S = 4;
  localparam int ST_V1 = 5;
  localparam int ST_V1S = 6;
  localparam int ST_XV = 7;
  localparam int ST_XVS = 8;
  localparam logic [8:0] ST_RST = 9'h000;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [0:0] CTRL_RST = 1'h1;

  // Biased rounding constant added at bit 15
  localparam logic [39:0] RND_ADD = 40'h00_0000_8000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Operations from the sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ADD16, OP_SUB16, OP_ADD32, OP_SUB32,
    OP_MUL, OP_MAC, OP_MSC, OP_XFER,
    OP_LSL, OP_LSR, OP_ASR, OP_EXP
  } mfsf_op_t;

endpackage : mfsf_pkg

//--- mfsf_seq_model.sv
// Purpose: Sequencer and register file stand-in for the datapath core
// Assumes: One op at a time; the result is taken one edge after the issue edge
// Notes:   Rounding is not exercised; its bias is left to a later bench
module mfsf_seq_model (
  input wire logic i_sys_clk,
  input wire logic i_res_valid,
  input wire logic [31:0] i_res_lo,
  input wire logic [31:0] i_res_hi,
  output logic o_op_valid,
  output mfsf_pkg::mfsf_op_t o_op_code,
  output logic o_op_unit,
  output logic o_op_frac,
  output logic o_op_a_signed,
  output logic o_op_b_signed,
  output logic [31:0] o_op_a,
  output logic [31:0] o_op_b
);
  timeunit 1ns;
  timeprecision 100ps;
  import mfsf_pkg::*;

  initial begin
    o_op_valid = 1'b0;
    o_op_code = OP_ADD16;
    {o_op_unit, o_op_frac, o_op_a_signed, o_op_b_signed} = '0;
    {o_op_a, o_op_b} = '0;
  end

  // ----------------------------------------------------------------
  // Issue one op and capture what comes back
  // ----------------------------------------------------------------
  // m packs unit, frac, a_signed, b_signed
  task issue(input mfsf_op_t c, input logic [3:0] m, input logic [31:0] a, b,
             output logic v, output logic [63:0] r);
    @(posedge i_sys_clk);
    o_op_valid <= 1'b1;
    o_op_code <= c;
    {o_op_unit, o_op_frac, o_op_a_signed, o_op_b_signed} <= m;
    o_op_a <= a;
    o_op_b <= b;
    @(posedge i_sys_clk);
    // Drop valid at once so the same op is not issued twice
    o_op_valid <= 1'b0;
    #1;
    v = i_res_valid;
    r = {i_res_hi, i_res_lo};
  endtask : issue
endmodule : mfsf_seq_model
